//--- core/sb2_cfg.svh
// Purpose: constants shared by the two-word burst sram port, both ends and the fifo
// Assumes: included by bare name from every file that needs it
// Notes:   widths default to the 36-bit variant; the 8-bit variant uses half-byte lanes
`ifndef SB2_CFG_SVH
`define SB2_CFG_SVH

`define SB2_DATA_W      36
`define SB2_ADDR_W      19
`define SB2_MEM_AW      19
`define SB2_NIB_W       4
`define SB2_LANE_W      9
`define SB2_NIB_MASKS   2
`define SB2_FIFO_DEPTH  4
`define SB2_HALF_DIV    4
`define SB2_RD_WR_GAP   2

`endif

//--- core/sb2_pkg.sv
// Purpose: types and width helpers for the two-word burst sram port
// Assumes: sb2_cfg.svh supplies the lane constants
// Notes:   the direction enum matches the level on the read/write pin
`include "sb2_cfg.svh"

package sb2_pkg;

  typedef enum logic {
    SB2_WRITE = 1'b0,
    SB2_READ  = 1'b1
  } sb2_dir_e;

  // what the host put on the link in the current slot
  typedef enum logic [1:0] {
    SB2_SLOT_IDLE  = 2'b00,
    SB2_SLOT_WRITE = 2'b01,
    SB2_SLOT_READ  = 2'b10
  } sb2_slot_e;

  function automatic int mask_count(input int data_w);
    return (data_w == 2 * `SB2_NIB_W) ? `SB2_NIB_MASKS : data_w / `SB2_LANE_W;
  endfunction

  function automatic int lane_width(input int data_w);
    return (data_w == 2 * `SB2_NIB_W) ? `SB2_NIB_W : `SB2_LANE_W;
  endfunction

endpackage

//--- core/sb2_link_if.sv
// Purpose: pins between the memory controller end and the sram end
// Assumes: both ends use the same DATA_W and ADDR_W
// Notes:   the shared data pins are resolved here from the sram output enable alone
`include "sb2_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

interface sb2_link_if #(
  parameter int DATA_W = `SB2_DATA_W,
  parameter int ADDR_W = `SB2_ADDR_W
);
  localparam int NM = sb2_pkg::mask_count(DATA_W);

  logic              k;
  logic              k_n;
  logic              c;
  logic              c_n;
  logic              cycle_define_n;
  logic              rd_wr_sel;
  logic [ADDR_W-1:0] addr;
  logic [NM-1:0]     lane_write_mask_n;
  logic [DATA_W-1:0] host_dq_out;
  logic              host_dq_oe;
  logic [DATA_W-1:0] dev_dq_out;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] dq;

  // the sram has priority; the host keeps off the pins around reads
  assign dq = dev_dq_oe ? dev_dq_out : host_dq_out;

  modport dev (
    input  k,
    input  k_n,
    input  c,
    input  c_n,
    input  cycle_define_n,
    input  rd_wr_sel,
    input  addr,
    input  lane_write_mask_n,
    input  dq,
    output dev_dq_out,
    output dev_dq_oe
  );

  modport host (
    output k,
    output k_n,
    output c,
    output c_n,
    output cycle_define_n,
    output rd_wr_sel,
    output addr,
    output lane_write_mask_n,
    output host_dq_out,
    output host_dq_oe,
    input  dq
  );

endinterface

`default_nettype wire

//--- core/sb2_fifo.sv
// Purpose: small request fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty come straight from the occupancy count
`include "sb2_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module sb2_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SB2_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = store_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      store_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- core/sb2_sram_dev.sv
// Purpose: sram end of the two-word burst port: decode, burst addressing,
//          write masking, read launch on the output or input clock pair
// Assumes: k/k_n and c/c_n are complementary pairs from one source;
//          reset_i is synchronous to k; single_clock_mode_i is a static strap
// Notes:   a write is committed to the array at the k edge after its load,
//          with forwarding so a read loaded on that edge sees the new data
`include "sb2_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module sb2_sram_dev #(
  parameter int DATA_W = `SB2_DATA_W,
  parameter int ADDR_W = `SB2_ADDR_W,
  parameter int MEM_AW = `SB2_MEM_AW
) (
  sb2_link_if.dev   link,
  input  wire logic reset_i,
  input  wire logic single_clock_mode_i,
  output logic      write_commit_o,
  output logic      read_launch_o
);
  localparam int NM  = sb2_pkg::mask_count(DATA_W);
  localparam int LW  = sb2_pkg::lane_width(DATA_W);
  // narrow variants keep the burst bit internal, so one more word address bit
  localparam int IAW = (DATA_W <= `SB2_LANE_W) ? ADDR_W + 1 : ADDR_W;

  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  // command capture, k domain
  logic              load;
  logic              load_rd;
  logic              load_wr;
  logic [ADDR_W-1:0] addr_q;
  logic              wr_pend_q;
  logic [DATA_W-1:0] wr_d0_q;
  logic [NM-1:0]     wr_m0_q;
  logic              rd_tog_q;
  logic [DATA_W-1:0] rd0_q;
  logic [DATA_W-1:0] rd1_q;
  logic              commit_q;

  // second write word, k_n domain
  logic [DATA_W-1:0] wr_d1_q;
  logic [NM-1:0]     wr_m1_q;

  // read launch, output clock pair (or k pair)
  logic              lclk;
  logic              lclk_n;
  logic              seen_tog_q;
  logic              oe_p_q;
  logic              oe_n_q;
  logic [DATA_W-1:0] q_p_q;
  logic [DATA_W-1:0] q_n_hold_q;
  logic [DATA_W-1:0] q_n_q;
  logic              ph_p_q;
  logic              ph_n_q;
  logic              sel_n;

  // write commit helpers
  logic [IAW-1:0]    wa0;
  logic [IAW-1:0]    wa1;
  logic [DATA_W-1:0] merge0;
  logic [DATA_W-1:0] merge1;

  function automatic logic [DATA_W-1:0] lane_bits(input logic [NM-1:0] mask_n);
    lane_bits = {DATA_W{1'b0}};
    for (int i = 0; i < DATA_W; i++) begin
      lane_bits[i] = ~mask_n[i / LW];
    end
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] d,
                                              input logic [NM-1:0]     mask_n);
    logic [DATA_W-1:0] en;
    en    = lane_bits(mask_n);
    merge = (old & ~en) | (d & en);
  endfunction

  function automatic logic [IAW-1:0] word_addr(input logic [ADDR_W-1:0] a,
                                               input logic              second);
    logic [ADDR_W:0] ext;
    ext = {(ADDR_W+1){1'b0}};
    if (DATA_W <= `SB2_LANE_W) begin
      ext = {a, second};
    end else begin
      // one-bit counter seeded from the burst start bit, wraps within the pair
      ext = {1'b0, a[ADDR_W-1:1], a[0] ^ second};
    end
    word_addr = ext[IAW-1:0];
  endfunction

  // read with forwarding from the write being committed on the same edge
  function automatic logic [DATA_W-1:0] fetch(input logic [IAW-1:0] w);
    fetch = mem[w[MEM_AW-1:0]];
    if (wr_pend_q && w[MEM_AW-1:0] == wa0[MEM_AW-1:0]) begin
      fetch = merge0;
    end else if (wr_pend_q && w[MEM_AW-1:0] == wa1[MEM_AW-1:0]) begin
      fetch = merge1;
    end
  endfunction

  assign load    = ~link.cycle_define_n;
  assign load_rd = load & (link.rd_wr_sel == sb2_pkg::SB2_READ);
  assign load_wr = load & (link.rd_wr_sel == sb2_pkg::SB2_WRITE);

  assign wa0    = word_addr(addr_q, 1'b0);
  assign wa1    = word_addr(addr_q, 1'b1);
  assign merge0 = merge(mem[wa0[MEM_AW-1:0]], wr_d0_q, wr_m0_q);
  assign merge1 = merge(mem[wa1[MEM_AW-1:0]], wr_d1_q, wr_m1_q);

  // control flags, k domain
  always_ff @(posedge link.k) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      rd_tog_q  <= 1'b0;
      commit_q  <= 1'b0;
    end else begin
      wr_pend_q <= load_wr;
      commit_q  <= wr_pend_q;
      if (load_rd) begin
        rd_tog_q <= ~rd_tog_q;
      end
    end
  end

  // address and first write word only move on a load cycle
  always_ff @(posedge link.k) begin
    if (load) begin
      addr_q  <= link.addr;
      wr_d0_q <= link.dq;
      wr_m0_q <= link.lane_write_mask_n;
    end
  end

  // both burst words are committed together on the next k edge
  always_ff @(posedge link.k) begin
    if (wr_pend_q) begin
      mem[wa0[MEM_AW-1:0]] <= merge0;
      mem[wa1[MEM_AW-1:0]] <= merge1;
    end
  end

  always_ff @(posedge link.k) begin
    if (load_rd) begin
      rd0_q <= fetch(word_addr(link.addr, 1'b0));
      rd1_q <= fetch(word_addr(link.addr, 1'b1));
    end
  end

  // second write word and its mask on the k_n edge of the load cycle
  always_ff @(posedge link.k_n) begin
    if (wr_pend_q) begin
      wr_d1_q <= link.dq;
      wr_m1_q <= link.lane_write_mask_n;
    end
  end

  // static strap, so the mux never switches while the clocks run
  assign lclk   = single_clock_mode_i ? link.k   : link.c;
  assign lclk_n = single_clock_mode_i ? link.k_n : link.c_n;

  // c follows k from the same source, so the toggle is compared directly;
  // the launch edge reads the value from before the coincident load edge
  always_ff @(posedge lclk) begin
    if (reset_i) begin
      seen_tog_q <= 1'b0;
      oe_p_q     <= 1'b0;
      ph_p_q     <= 1'b0;
      q_p_q      <= {DATA_W{1'b0}};
      q_n_hold_q <= {DATA_W{1'b0}};
    end else begin
      seen_tog_q <= rd_tog_q;
      oe_p_q     <= (rd_tog_q != seen_tog_q);
      ph_p_q     <= ph_n_q;
      q_p_q      <= rd0_q;
      // rd1_q may be replaced by the next load before the negative edge
      q_n_hold_q <= rd1_q;
    end
  end

  always_ff @(posedge lclk_n) begin
    if (reset_i) begin
      oe_n_q <= 1'b0;
      ph_n_q <= 1'b0;
      q_n_q  <= {DATA_W{1'b0}};
    end else begin
      oe_n_q <= oe_p_q;
      ph_n_q <= ~ph_p_q;
      q_n_q  <= q_n_hold_q;
    end
  end

  // phases differ after a negative edge, match after a positive one
  assign sel_n           = (ph_p_q != ph_n_q);
  assign link.dev_dq_out = sel_n ? q_n_q  : q_p_q;
  assign link.dev_dq_oe  = sel_n ? oe_n_q : oe_p_q;

  assign write_commit_o = commit_q;
  assign read_launch_o  = oe_p_q;

endmodule

`default_nettype wire

//--- core/sb2_sram_host.sv
// Purpose: memory controller end: queues requests, makes the link clocks,
//          issues one command per link cycle, collects read bursts
// Assumes: 2*HALF_DIV clk_i cycles per link cycle, HALF_DIV even and >= 4
// Notes:   a write waits two idle slots after a read to avoid pin contention
`include "sb2_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module sb2_sram_host #(
  parameter int DATA_W     = `SB2_DATA_W,
  parameter int ADDR_W     = `SB2_ADDR_W,
  parameter int HALF_DIV   = `SB2_HALF_DIV,
  parameter int FIFO_DEPTH = `SB2_FIFO_DEPTH
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_i,
  input  wire logic                                  req_valid_i,
  output logic                                       req_ready_o,
  input  wire logic                                  req_read_i,
  input  wire logic [ADDR_W-1:0]                     req_addr_i,
  input  wire logic [DATA_W-1:0]                     req_wdata0_i,
  input  wire logic [DATA_W-1:0]                     req_wdata1_i,
  input  wire logic [sb2_pkg::mask_count(DATA_W)-1:0] req_mask0_n_i,
  input  wire logic [sb2_pkg::mask_count(DATA_W)-1:0] req_mask1_n_i,
  output logic                                       rsp_valid_o,
  output logic [DATA_W-1:0]                          rsp_rdata0_o,
  output logic [DATA_W-1:0]                          rsp_rdata1_o,
  sb2_link_if.host                                   link
);
  localparam int NM = sb2_pkg::mask_count(DATA_W);
  localparam int PW = $clog2(2 * HALF_DIV);
  localparam int EW = 1 + ADDR_W + 2 * DATA_W + 2 * NM;
  localparam logic [PW-1:0] PH_RISE   = PW'(2 * HALF_DIV - 1);
  localparam logic [PW-1:0] PH_FALL   = PW'(HALF_DIV - 1);
  localparam logic [PW-1:0] PH_MID_HI = PW'(HALF_DIV / 2 - 1);
  localparam logic [PW-1:0] PH_MID_LO = PW'(HALF_DIV + HALF_DIV / 2 - 1);
  localparam logic [1:0]    GAP       = 2'(`SB2_RD_WR_GAP);

  logic [PW-1:0]         ph_q;
  logic                  k_q;
  sb2_pkg::sb2_slot_e    slot_q;
  logic                  cdn_q;
  logic                  rw_q;
  logic [ADDR_W-1:0]     addr_q;
  logic [DATA_W-1:0]     hdq_q;
  logic [NM-1:0]         hmask_q;
  logic                  hoe_q;
  logic [DATA_W-1:0]     d1_q;
  logic [NM-1:0]         m1_q;
  logic [1:0]            gap_q;
  logic                  rd_a_q;
  logic                  rd_b_q;
  logic [DATA_W-1:0]     dq_s1_q;
  logic [DATA_W-1:0]     dq_s2_q;
  logic [DATA_W-1:0]     rdata0_q;
  logic [DATA_W-1:0]     rdata1_q;
  logic                  rsp_valid_q;

  logic                  f_valid;
  logic                  f_ready;
  logic [EW-1:0]         f_data;
  logic                  h_read;
  logic [ADDR_W-1:0]     h_addr;
  logic [DATA_W-1:0]     h_d0;
  logic [DATA_W-1:0]     h_d1;
  logic [NM-1:0]         h_m0;
  logic [NM-1:0]         h_m1;
  logic                  ev_rise;
  logic                  ev_fall;
  logic                  ev_mid_lo;
  logic                  ev_mid_hi;

  sb2_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) i_sb2_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   ({req_read_i, req_addr_i, req_wdata0_i, req_wdata1_i,
                   req_mask0_n_i, req_mask1_n_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  assign {h_read, h_addr, h_d0, h_d1, h_m0, h_m1} = f_data;

  assign ev_rise   = (ph_q == PH_RISE);
  assign ev_fall   = (ph_q == PH_FALL);
  assign ev_mid_lo = (ph_q == PH_MID_LO);
  assign ev_mid_hi = (ph_q == PH_MID_HI);
  // drain stalls between slots, and a write also stalls while a read still owns the pins
  assign f_ready   = ev_mid_lo & f_valid & (h_read | (gap_q == 2'h0));

  // link clock divider
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ph_q <= '0;
      k_q  <= 1'b0;
    end else begin
      ph_q <= ev_rise ? '0 : ph_q + 1'b1;
      if (ev_rise) begin
        k_q <= 1'b1;
      end else if (ev_fall) begin
        k_q <= 1'b0;
      end
    end
  end

  // slot control: commands change mid low phase, clear of both k edges
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slot_q <= sb2_pkg::SB2_SLOT_IDLE;
      cdn_q  <= 1'b1;
      hoe_q  <= 1'b0;
      gap_q  <= 2'h0;
    end else if (ev_mid_lo) begin
      if (f_ready) begin
        slot_q <= h_read ? sb2_pkg::SB2_SLOT_READ : sb2_pkg::SB2_SLOT_WRITE;
        cdn_q  <= 1'b0;
        hoe_q  <= ~h_read;
      end else begin
        slot_q <= sb2_pkg::SB2_SLOT_IDLE;
        cdn_q  <= 1'b1;
        hoe_q  <= 1'b0;
      end
      if (f_ready && h_read) begin
        gap_q <= GAP;
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end
    end
  end

  // first word stands at the k rise, second word at the k_n rise
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rw_q    <= sb2_pkg::SB2_WRITE;
      addr_q  <= '0;
      hdq_q   <= '0;
      hmask_q <= '1;
      d1_q    <= '0;
      m1_q    <= '1;
    end else if (ev_mid_lo && f_ready) begin
      rw_q    <= h_read;
      addr_q  <= h_addr;
      hdq_q   <= h_d0;
      hmask_q <= h_m0;
      d1_q    <= h_d1;
      m1_q    <= h_m1;
    end else if (ev_mid_hi && slot_q == sb2_pkg::SB2_SLOT_WRITE) begin
      hdq_q   <= d1_q;
      hmask_q <= m1_q;
    end
  end

  // the data pins come from the other end, so two flops before use
  always_ff @(posedge clk_i) begin
    dq_s1_q <= link.dq;
    dq_s2_q <= dq_s1_q;
  end

  // read loaded at rise n is returned during link cycle n+1
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_a_q      <= 1'b0;
      rd_b_q      <= 1'b0;
      rdata0_q    <= '0;
      rdata1_q    <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= ev_rise & rd_b_q;
      if (ev_rise) begin
        rd_a_q <= (slot_q == sb2_pkg::SB2_SLOT_READ);
        rd_b_q <= rd_a_q;
      end
      if (ev_fall && rd_b_q) begin
        rdata0_q <= dq_s2_q;
      end
      if (ev_rise && rd_b_q) begin
        rdata1_q <= dq_s2_q;
      end
    end
  end

  assign link.k                 = k_q;
  assign link.k_n               = ~k_q;
  assign link.c                 = k_q;
  assign link.c_n               = ~k_q;
  assign link.cycle_define_n    = cdn_q;
  assign link.rd_wr_sel         = rw_q;
  assign link.addr              = addr_q;
  assign link.lane_write_mask_n = hmask_q;
  assign link.host_dq_out       = hdq_q;
  assign link.host_dq_oe        = hoe_q;

  assign rsp_valid_o  = rsp_valid_q;
  assign rsp_rdata0_o = rdata0_q;
  assign rsp_rdata1_o = rdata1_q;

endmodule

`default_nettype wire

//--- dv/sb2_link_props.sv
// Purpose: link properties of the two-word burst sram port
// Assumes: reset_i is the sram end reset; the c pair mirrors the k pair
// Notes:   helpers remember the read loads of the last two k edges and the write load of the last one
`timescale 1ns/1ns
`default_nettype none

module sb2_link_props (
  input wire logic reset_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic cycle_define_n_i,
  input wire logic rd_wr_sel_i,
  input wire logic host_dq_oe_i,
  input wire logic dev_dq_oe_i
);
  logic rd_load;
  logic wr_load;
  logic rd_d1_q;
  logic rd_d2_q;
  logic wr_d1_q;

  assign rd_load = !cycle_define_n_i && rd_wr_sel_i;
  assign wr_load = !cycle_define_n_i && !rd_wr_sel_i;

  always_ff @(posedge k_i) begin
    if (reset_i) begin
      rd_d1_q <= 1'b0;
      rd_d2_q <= 1'b0;
      wr_d1_q <= 1'b0;
    end else begin
      rd_d1_q <= rd_load;
      rd_d2_q <= rd_d1_q;
      wr_d1_q <= wr_load;
    end
  end

  default clocking cb @(posedge k_i); endclocking
  default disable iff (reset_i);

  a_read_oe_on: assert property (rd_load |-> ##2 dev_dq_oe_i)
    else $error("read load did not drive the data pins");
  a_idle_oe_off: assert property (!rd_load |-> ##2 !dev_dq_oe_i)
    else $error("data pins driven without a read load");
  a_no_contention: assert property (!(dev_dq_oe_i && host_dq_oe_i))
    else $error("both ends drive the data pins");
  a_write_word0: assert property (wr_load |-> host_dq_oe_i)
    else $error("write load without first data word");
  a_host_off_read: assert property (rd_load |-> ##1 !host_dq_oe_i)
    else $error("host drives pins during read burst");
  a_clock_pairs: assert property (k_n_i && c_n_i && !c_i)
    else $error("clock pairs not aligned at k rise");
  a_word1_window: assert property (@(posedge k_n_i) disable iff (reset_i)
    wr_d1_q |-> host_dq_oe_i)
    else $error("second write word missing at k_n");
  a_oe_burst: assert property (@(posedge k_n_i) disable iff (reset_i)
    dev_dq_oe_i == rd_d2_q)
    else $error("read burst not two words long");
endmodule

`default_nettype wire

//--- dv/sync_burst2_sram_port_bench.sv
// Purpose: both ends of the two-word burst sram port joined and exercised
// Assumes: 36-bit variant, array shrunk to 64 words, addresses kept below 64
// Notes:   a reference array follows every write, masks applied per lane
`timescale 1ns/1ns
`default_nettype none

module sync_burst2_sram_port_bench;
  localparam int DW = 36;
  localparam int AW = 19;
  localparam int NM = 4;
  logic          clk_i     = 1'b0;
  logic          reset_i   = 1'b1;
  logic          dev_reset = 1'b1;
  logic          scm       = 1'b0;
  logic          req_valid = 1'b0;
  logic          req_read  = 1'b0;
  logic [AW-1:0] req_addr  = '0;
  logic [DW-1:0] wd0       = '0;
  logic [DW-1:0] wd1       = '0;
  logic [NM-1:0] m0        = '1;
  logic [NM-1:0] m1        = '1;
  logic          req_ready;
  logic          rsp_valid;
  logic [DW-1:0] rd0;
  logic [DW-1:0] rd1;
  logic          commit;
  logic          launch;
  logic [DW-1:0] mem [0:63];
  int            fail_count = 0;
  int            tests_run  = 0;
  int            cycles     = 0;
  int            commits    = 0;
  int            launches   = 0;
  int            writes     = 0;
  int            reads      = 0;
  int            saw_full   = 0;

  sb2_link_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
  sb2_sram_host #(.DATA_W(DW), .ADDR_W(AW), .HALF_DIV(4), .FIFO_DEPTH(4)) i_sb2_sram_host (
    .clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid), .req_ready_o(req_ready),
    .req_read_i(req_read), .req_addr_i(req_addr), .req_wdata0_i(wd0), .req_wdata1_i(wd1),
    .req_mask0_n_i(m0), .req_mask1_n_i(m1), .rsp_valid_o(rsp_valid), .rsp_rdata0_o(rd0),
    .rsp_rdata1_o(rd1), .link(link.host));
  sb2_sram_dev #(.DATA_W(DW), .ADDR_W(AW), .MEM_AW(6)) i_sb2_sram_dev (
    .link(link.dev), .reset_i(dev_reset), .single_clock_mode_i(scm),
    .write_commit_o(commit), .read_launch_o(launch));
  sb2_link_props i_sb2_link_props (
    .reset_i(dev_reset), .k_i(link.k), .k_n_i(link.k_n), .c_i(link.c), .c_n_i(link.c_n),
    .cycle_define_n_i(link.cycle_define_n), .rd_wr_sel_i(link.rd_wr_sel),
    .host_dq_oe_i(link.host_dq_oe), .dev_dq_oe_i(link.dev_dq_oe));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // commit and launch pulses last one k cycle, so each is seen at one k edge
  always @(posedge link.k) begin
    commits += (commit === 1'b1);
    launches += (launch === 1'b1);
  end

  always @(posedge clk_i) begin
    cycles++;
    if (req_ready === 1'b0) begin
      saw_full = 1;
    end
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready is sampled settled before the taking edge; one idle edge follows
  task automatic send(input logic rd, input logic [5:0] a, input logic [DW-1:0] d0,
                      input logic [DW-1:0] d1, input logic [NM-1:0] n0, input logic [NM-1:0] n1);
    req_valid = 1'b1;
    req_read = rd;
    req_addr = {13'h0000, a};
    wd0 = d0;
    wd1 = d1;
    m0 = n0;
    m1 = n1;
    // a queue that never drains is caught by the cycle ceiling
    while (req_ready !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    req_valid = 1'b0;
    if (rd) begin
      reads++;
    end else begin
      writes++;
      for (int i = 0; i < NM; i++) begin
        if (!n0[i]) mem[a][i*9 +: 9] = d0[i*9 +: 9];
        if (!n1[i]) mem[a ^ 6'h01][i*9 +: 9] = d1[i*9 +: 9];
      end
    end
    @(posedge clk_i);
    #1;
  endtask

  task automatic read_chk(input logic [5:0] a);
    send(1'b1, a, '0, '0, '1, '1);
    while (rsp_valid !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    chk(rd0, mem[a]);
    chk(rd1, mem[a ^ 6'h01]);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    // the sram end needs k running across its reset
    repeat (40) @(posedge clk_i);
    #1;
    dev_reset = 1'b0;
    // six back-to-back writes overrun the four-deep queue; one starts on bit 0 set
    for (int i = 0; i < 6; i++) begin
      send(1'b0, 6'h10 + 6'(2 * i) + 6'(i == 5), 36'h1_2345_6780 + 36'(i), 36'hf_edcb_a980 - 36'(i),
           4'h0, 4'h0);
    end
    chk_cnt(saw_full, 1);
    for (int i = 0; i < 6; i++) begin
      read_chk(6'h10 + 6'(2 * i));
    end
    // masked lanes keep their old contents, per word
    send(1'b0, 6'h20, 36'hf_ffff_ffff, 36'hf_ffff_ffff, 4'h0, 4'h0);
    send(1'b0, 6'h22, 36'hf_ffff_ffff, 36'hf_ffff_ffff, 4'h0, 4'h0);
    send(1'b0, 6'h20, 36'h0, 36'h0, 4'ha, 4'h5);
    send(1'b0, 6'h23, 36'h0, 36'h0, 4'h7, 4'he);
    // queued right behind the last write, so it takes the forwarded words
    read_chk(6'h22);
    read_chk(6'h20);
    // two of the first six bursts read again, launched on the k pair
    scm = 1'b1;
    read_chk(6'h10);
    read_chk(6'h1a);
    repeat (40) @(posedge clk_i);
    chk_cnt(commits, writes);
    chk_cnt(launches, reads);
    report_and_stop();
  end
endmodule

`default_nettype wire
